// [core/pcstk_core.sv]
// Program counter sequencing, 16-entry return stack and context shadows.
// Assumes the decoder issues at most one command per clock and that the
// AXI4-Lite master keeps one write and one read in flight at a time.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - 15-bit counter, low byte readable and writable
// R2 - Upper seven bits only via high latch
// R3 - Any reset clears the counter
// R4 - Low-byte write loads upper bits from latch
// R5 - Call: operand 10:0, latch 6:3 above
// R6 - Register call: working reg low, latch high
// R7 - Relative branch adds unsigned working reg
// R8 - Literal branch adds signed nine-bit offset
// R9 - Sixteen 15-bit entries, own address space
// R10 - Push on calls and vectors, pop on returns
// R11 - Push and pop leave latch alone
// R12 - Fault reset off: stack wraps circularly
// R13 - Overflow, underflow flags set on faults always
// R14 - Fault reset on: reset and flag status
// R15 - Top entry pair shows pointer-selected entry
// R16 - Five-bit stack pointer detects faults
// R17 - Push increments first, pop reads first
// R18 - Software adjusts pointer carefully with interrupts
// R19 - Shadow copies of core context registers
// R20 - Top bank reserved to debug, shadows and stack window excepted
// R21 - Sequential fetch increments counter, wraps
module pcstk_core
	import pcstk_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Core side
	input  wire pcstk_cmd_type cmd,
	input  wire logic          save_context,
	input  wire pcstk_context_type live_context,
	output logic [14:0]        pc,
	output logic               fault_reset,
	// AXI4-Lite write address
	input  wire logic [31:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Entry storage has no reset: stale return addresses are harmless
	logic [14:0]       stack_mem [DEPTH];
	logic [4:0]        stack_index;
	logic [6:0]        pc_high_latch;
	logic              fault_reset_enable;
	logic              debug_mode;
	logic              stack_overflow_flag;
	logic              stack_underflow_flag;
	pcstk_context_type shadow;
	// Parked halves of a write
	logic [31:0]       aw_addr;
	logic              aw_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              w_held;

	// Word index of a byte address; bits above 13 are ignored, so the map
	// repeats every 16 KB of address space
	function automatic logic [11:0] word_index(input logic [31:0] a);
		word_index = a[13:2];
	endfunction

	// The top bank is debug only, except for the shadows and the stack
	// window, which user code must reach as well
	function automatic logic allowed(input logic [11:0] idx, input logic dbg);
		allowed = dbg || idx < IDX_DEBUG_BANK
			|| (idx >= IDX_STATUS_SHADOW && idx <= IDX_TOP_ENTRY_HIGH && idx != IDX_UNUSED_GAP); // see R20
	endfunction

	// ----------------------------------------------------------------
	// Write channel capture (address and data in either order)
	// ----------------------------------------------------------------
	logic        wr_fire;
	logic [11:0] wr_idx;
	logic        wr_ok;
	// A write commits in the cycle after both halves are parked
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx  = word_index(aw_addr);
	assign wr_ok   = allowed(wr_idx, debug_mode) && w_strb[0];

	// Address and data are parked separately; the response fires once
	// both are in, so a master may offer them in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 32'h0000_0000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= allowed(wr_idx, debug_mode) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Stack pointer arithmetic
	// ----------------------------------------------------------------
	logic       is_push;
	logic       is_pop;
	logic [4:0] next_index_push;
	logic [4:0] next_index_pop;
	logic       push_fault;
	logic       pop_fault;
	logic [3:0] slot;
	// Pushes wrap the pointer inside sixteen slots; bit 4 only marks empty
	assign is_push = cmd.op == PCSTK_OP_CALL || cmd.op == PCSTK_OP_CALL_WORKING
		|| cmd.op == PCSTK_OP_VECTOR; // see R10
	assign is_pop  = cmd.op == PCSTK_OP_RETURN; // see R10
	assign next_index_push = stack_index + 5'h01; // see R16
	assign next_index_pop  = stack_index - 5'h01;
	// Index 15 is the top level; 31 means empty
	assign push_fault = is_push && stack_index == 5'h0F; // see R16
	assign pop_fault  = is_pop && stack_index == 5'h1F;
	// Slot named by the pointer, used by pops and the software window
	assign slot = stack_index[3:0];

	// ----------------------------------------------------------------
	// Program counter (software write of low byte counts as R4 too)
	// ----------------------------------------------------------------
	logic [14:0] pc_plus1;
	logic        sw_pcl_write;
	// Incremented counter, also the base of both relative branches
	assign pc_plus1 = pc + 15'h0001; // see R21
	// A bus write to the low byte acts like a core write to it
	assign sw_pcl_write = wr_fire && wr_ok && wr_idx == IDX_PC_LOW_BYTE;

	// A software low-byte write beats a core command in the same cycle;
	// a fault reset beats both, so the counter restarts at zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn || fault_reset)
			pc <= PC_RESET; // see R3
		else if (sw_pcl_write)
			pc <= {pc_high_latch, w_data[7:0]}; // see R1, R2, R4
		else
		begin
			case (cmd.op)
				PCSTK_OP_STEP:           pc <= pc_plus1; // see R21
				PCSTK_OP_WRITE_LOW:      pc <= {pc_high_latch, cmd.value}; // see R4
				PCSTK_OP_CALL:           pc <= {pc_high_latch[6:3], cmd.operand}; // see R5
				PCSTK_OP_CALL_WORKING:   pc <= {pc_high_latch, cmd.value}; // see R6
				PCSTK_OP_BRANCH_WORKING: pc <= pc_plus1 + {7'h00, cmd.value}; // see R7
				PCSTK_OP_BRANCH_LITERAL: pc <= pc_plus1 + {{6{cmd.operand[8]}}, cmd.operand[8:0]}; // see R8
				PCSTK_OP_VECTOR:         pc <= cmd.vector;
				PCSTK_OP_RETURN:         pc <= stack_mem[slot]; // see R17
				default:                 pc <= pc;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Return stack and pointer
	// ----------------------------------------------------------------
	logic [14:0] push_value;
	// A vector saves the address it interrupted; calls save the next one
	assign push_value = (cmd.op == PCSTK_OP_VECTOR) ? pc : pc_plus1;

	// Core pushes and pops win over software pointer or entry writes in
	// the same cycle, so the return path is never corrupted by the bus
	always_ff @(posedge aclk)
	begin
		if (!aresetn || fault_reset)
			stack_index <= STACK_INDEX_RESET;
		else if (is_push)
		begin
			stack_index <= {1'b0, next_index_push[3:0]}; // see R12, R17
			stack_mem[next_index_push[3:0]] <= push_value; // see R9, R17
		end
		else if (is_pop)
			stack_index <= next_index_pop; // see R17
		else if (wr_fire && wr_ok)
		begin
			// Software moves the pointer, then reaches the selected entry
			if (wr_idx == IDX_STACK_INDEX)
				stack_index <= w_data[4:0]; // see R15, R18
			else if (wr_idx == IDX_TOP_ENTRY_LOW)
				stack_mem[slot][7:0] <= w_data[7:0]; // see R15
			else if (wr_idx == IDX_TOP_ENTRY_HIGH)
				stack_mem[slot][14:8] <= w_data[6:0]; // see R15
		end
	end

	// ----------------------------------------------------------------
	// Fault flags and fault reset pulse
	// ----------------------------------------------------------------
	// The pulse lasts one cycle: by the next edge the pointer has left
	// the fault position, so the condition cannot repeat by itself
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stack_overflow_flag  <= 1'b0;
			stack_underflow_flag <= 1'b0;
			fault_reset          <= 1'b0;
		end
		else
		begin
			// Hardware set wins over a software clear in the same cycle
			if (push_fault)
				stack_overflow_flag <= 1'b1; // see R13
			else if (wr_fire && wr_ok && wr_idx == IDX_POWER_CONTROL_STATUS && !w_data[PWR_STATUS_OVF_BIT])
				stack_overflow_flag <= 1'b0;
			if (pop_fault)
				stack_underflow_flag <= 1'b1; // see R13
			else if (wr_fire && wr_ok && wr_idx == IDX_POWER_CONTROL_STATUS && !w_data[PWR_STATUS_UNF_BIT])
				stack_underflow_flag <= 1'b0;
			// Pulse only with the option bit set; the flags are set regardless
			fault_reset <= fault_reset_enable && (push_fault || pop_fault); // see R14
		end
	end

	// ----------------------------------------------------------------
	// Configuration, high latch and shadows
	// ----------------------------------------------------------------
	// Shadows follow the live context whenever the core asks; a software
	// write to one shadow byte in that same cycle takes precedence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc_high_latch      <= 7'h00;
			fault_reset_enable <= 1'b0;
			debug_mode         <= 1'b0;
			shadow             <= '0;
		end
		else
		begin
			if (save_context)
				shadow <= live_context; // see R19
			// The latch is never touched by stack traffic
			if (wr_fire && wr_ok) // see R11
			begin
				case (wr_idx)
					IDX_PC_HIGH_LATCH:        pc_high_latch <= w_data[6:0];
					IDX_CONTROL:
					begin
						fault_reset_enable <= w_data[CTRL_FAULT_RESET_BIT];
						debug_mode         <= w_data[CTRL_DEBUG_BIT];
					end
					IDX_STATUS_SHADOW:        shadow.status  <= w_data[7:0]; // see R19
					IDX_WORKING_REG_SHADOW:   shadow.working <= w_data[7:0];
					IDX_BANK_SELECT_SHADOW:   shadow.bank    <= w_data[7:0];
					IDX_PC_LATCH_SHADOW:      shadow.latch   <= w_data[7:0];
					IDX_POINTER0_LOW_SHADOW:  shadow.p0_low  <= w_data[7:0];
					IDX_POINTER0_HIGH_SHADOW: shadow.p0_high <= w_data[7:0];
					IDX_POINTER1_LOW_SHADOW:  shadow.p1_low  <= w_data[7:0];
					IDX_POINTER1_HIGH_SHADOW: shadow.p1_high <= w_data[7:0];
					default:                  fault_reset_enable <= fault_reset_enable;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel: one-cycle lookup, data held until rready
	// ----------------------------------------------------------------
	// Byte-wide lookup for the read channel; unmapped words outside the
	// debug bank read as zero
	function automatic logic [7:0] read_reg(input logic [11:0] idx);
		case (idx)
			IDX_PC_LOW_BYTE:          read_reg = pc[7:0]; // see R1
			IDX_PC_HIGH_LATCH:        read_reg = {1'b0, pc_high_latch};
			IDX_CONTROL:              read_reg = {6'h00, debug_mode, fault_reset_enable};
			IDX_POWER_CONTROL_STATUS: read_reg = {6'h00, stack_underflow_flag, stack_overflow_flag};
			IDX_STATUS_SHADOW:        read_reg = shadow.status;
			IDX_WORKING_REG_SHADOW:   read_reg = shadow.working;
			IDX_BANK_SELECT_SHADOW:   read_reg = shadow.bank;
			IDX_PC_LATCH_SHADOW:      read_reg = shadow.latch;
			IDX_POINTER0_LOW_SHADOW:  read_reg = shadow.p0_low;
			IDX_POINTER0_HIGH_SHADOW: read_reg = shadow.p0_high;
			IDX_POINTER1_LOW_SHADOW:  read_reg = shadow.p1_low;
			IDX_POINTER1_HIGH_SHADOW: read_reg = shadow.p1_high;
			IDX_STACK_INDEX:          read_reg = {3'h0, stack_index};
			IDX_TOP_ENTRY_LOW:        read_reg = stack_mem[slot][7:0]; // see R15
			IDX_TOP_ENTRY_HIGH:       read_reg = {1'b0, stack_mem[slot][14:8]};
			default:                  read_reg = 8'h00; // PC upper bits read as zero, see R2
		endcase
	endfunction

	// A read address is taken only while no answer is pending, so rdata
	// cannot change under a waiting master
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				if (allowed(word_index(s_axi_araddr), debug_mode))
				begin
					s_axi_rdata <= {24'h000000, read_reg(word_index(s_axi_araddr))};
					s_axi_rresp <= RESP_OKAY;
				end
				else
				begin
					// Refused reads return zero with an error response
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR; // see R20
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [inc/pcstk_pkg.sv]
// Package for the program counter and return stack block.
// Assumes a single clock domain and an AXI4-Lite register port.
`default_nettype none
package pcstk_pkg;

	// ----------------------------------------------------------------
	// Register word indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_STATUS_SHADOW       = 12'hFE4;
	localparam logic [11:0] IDX_WORKING_REG_SHADOW  = 12'hFE5;
	localparam logic [11:0] IDX_BANK_SELECT_SHADOW  = 12'hFE6;
	localparam logic [11:0] IDX_PC_LATCH_SHADOW     = 12'hFE7;
	localparam logic [11:0] IDX_POINTER0_LOW_SHADOW = 12'hFE8;
	localparam logic [11:0] IDX_POINTER0_HIGH_SHADOW = 12'hFE9;
	localparam logic [11:0] IDX_POINTER1_LOW_SHADOW = 12'hFEA;
	localparam logic [11:0] IDX_POINTER1_HIGH_SHADOW = 12'hFEB;
	localparam logic [11:0] IDX_STACK_INDEX         = 12'hFED;
	localparam logic [11:0] IDX_TOP_ENTRY_LOW       = 12'hFEE;
	localparam logic [11:0] IDX_TOP_ENTRY_HIGH      = 12'hFEF;
	// Block's own registers
	localparam logic [11:0] IDX_PC_LOW_BYTE         = 12'hF00;
	localparam logic [11:0] IDX_PC_HIGH_LATCH       = 12'hF01;
	localparam logic [11:0] IDX_PC_UPPER_BITS       = 12'hF02;
	localparam logic [11:0] IDX_CONTROL             = 12'hF03;
	localparam logic [11:0] IDX_POWER_CONTROL_STATUS = 12'hF04;
	// Start of the debug-only top bank, and the unused word between the shadows and the stack window
	localparam logic [11:0] IDX_DEBUG_BANK          = 12'hF80;
	localparam logic [11:0] IDX_UNUSED_GAP          = 12'hFEC;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_FAULT_RESET_BIT = 0;
	localparam int          CTRL_DEBUG_BIT       = 1;
	localparam int          PWR_STATUS_OVF_BIT   = 0;
	localparam int          PWR_STATUS_UNF_BIT   = 1;
	localparam logic [4:0]  STACK_INDEX_RESET    = 5'h1F;
	localparam logic [14:0] PC_RESET             = 15'h0000;
	localparam logic [1:0]  RESP_OKAY            = 2'h0;
	localparam logic [1:0]  RESP_SLVERR          = 2'h2;

	// ----------------------------------------------------------------
	// Core command carrier
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		PCSTK_OP_NONE,
		PCSTK_OP_STEP,
		PCSTK_OP_WRITE_LOW,
		PCSTK_OP_CALL,
		PCSTK_OP_CALL_WORKING,
		PCSTK_OP_BRANCH_WORKING,
		PCSTK_OP_BRANCH_LITERAL,
		PCSTK_OP_VECTOR,
		PCSTK_OP_RETURN
	} pcstk_op_type;

	typedef struct packed
	{
		pcstk_op_type op;
		logic [10:0]  operand;     // call target or signed 9-bit offset
		logic [7:0]   value;       // working reg or low-byte result
		logic [14:0]  vector;      // interrupt vector address
	} pcstk_cmd_type;

	typedef struct packed
	{
		logic [7:0] status;
		logic [7:0] working;
		logic [7:0] bank;
		logic [7:0] latch;
		logic [7:0] p0_low;
		logic [7:0] p0_high;
		logic [7:0] p1_low;
		logic [7:0] p1_high;
	} pcstk_context_type;

endpackage
`default_nettype wire

// [test/pcstk_props.sv]
// Port-level assertions for the program counter and return stack.
// Assumes binding to pcstk_core; commands and writes never overlap.
`timescale 1ns/1ps
`default_nettype none
module pcstk_props
	import pcstk_pkg::*;
(
	// Clock, reset and core side
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire pcstk_cmd_type cmd,
	input wire logic [14:0]   pc,
	input wire logic          fault_reset,
	// Bus answers
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [1:0]    s_axi_bresp
);
	// ----------------------------------------------------------------
	// Flow of the counter
	// ----------------------------------------------------------------
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_STEP: assert property (cmd.op == PCSTK_OP_STEP && !fault_reset |=> pc == $past(pc) + 15'h1)
		else $error("step did not add one");
	AST_BRANCH_REG: assert property (cmd.op == PCSTK_OP_BRANCH_WORKING && !fault_reset |=>
		pc == $past(pc) + 15'h1 + {7'h0, $past(cmd.value)})
		else $error("register branch target wrong");
	AST_BRANCH_LIT: assert property (cmd.op == PCSTK_OP_BRANCH_LITERAL && !fault_reset |=>
		pc == $past(pc) + 15'h1 + {{6{$past(cmd.operand[8])}}, $past(cmd.operand[8:0])})
		else $error("literal branch target wrong");
	AST_CALL: assert property (cmd.op == PCSTK_OP_CALL && !fault_reset |=> pc[10:0] == $past(cmd.operand))
		else $error("call target wrong");
	// Return straight after a call must land on the word after the call
	AST_CALLRET: assert property (cmd.op == PCSTK_OP_CALL ##1 cmd.op == PCSTK_OP_RETURN && !fault_reset
		|=> pc == $past(pc, 2) + 15'h1)
		else $error("return address wrong");
	AST_VEC: assert property (cmd.op == PCSTK_OP_VECTOR |=> fault_reset || pc == $past(cmd.vector))
		else $error("vector not taken");
	AST_FAULT: assert property (fault_reset |=> !fault_reset && pc == PC_RESET)
		else $error("fault reset not a clearing pulse");
	AST_ROSE: assert property ($rose(aresetn) |-> pc == PC_RESET && !s_axi_rvalid && !s_axi_bvalid)
		else $error("state after reset wrong");
	// ----------------------------------------------------------------
	// Bus answers hold until taken
	// ----------------------------------------------------------------
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
endmodule
bind pcstk_core pcstk_props u_pcstk_props
(
	.aclk, .aresetn, .cmd, .pc, .fault_reset,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp
);
`default_nettype wire

// [test/pcstk_cpu_model.sv]
// Decoder stand-in: puts one core command on the bus per clock.
// Assumes the bench calls issue from one thread only.
`timescale 1ns/1ps
`default_nettype none
module pcstk_cpu_model
	import pcstk_pkg::*;
(
	// Clock
	input  wire logic         aclk,
	// Command to the counter block
	output var pcstk_cmd_type cmd
);
	// Idle command until the bench asks for one
	initial
	begin
		cmd = '0;
	end
	// Vectors come only on request, so pointer edits are never raced
	task automatic issue(input pcstk_cmd_type c);
		@(posedge aclk);
		cmd <= c;
	endtask
endmodule
`default_nettype wire

// [test/pcstk_core_tb.sv]
// Self-checking bench for the program counter and return stack.
// Assumes the checker binds itself to the core.
`timescale 1ns/1ps
`default_nettype none
module pcstk_core_tb
	import pcstk_pkg::*;
;
	logic              aclk = 1'h0;
	logic              aresetn = 1'h0;
	logic              save_context = 1'h0;
	pcstk_context_type live_context = '0;
	pcstk_cmd_type     cmd;
	logic [14:0]       pc;
	logic              fault_reset;
	logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]       s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic [33:0]       q_bus[$];
	logic [14:0]       q_pc[$];
	logic              pstb = 1'h0;
	logic [31:0]       seed = 32'h000038F8;
	logic [63:0]       ctx;
	logic [7:0]        v;
	logic [14:0]       epc;
	int                n_mismatch = 0, checks = 0, cyc = 0;

	pcstk_cpu_model u_pcstk_cpu_model
	(
		.aclk, .cmd
	);
	pcstk_core u_pcstk_core
	(
		.aclk, .aresetn, .cmd, .save_context, .live_context, .pc, .fault_reset,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);

	// 200 MHz clock
	always #2.5 aclk = ~aclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t bus exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_pc(input logic [14:0] e, input logic [14:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t pc exp %h got %h", $time, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		q_bus.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= {18'h0, i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		q_bus.push_back({r, 24'h0, d});
		@(posedge aclk);
		s_axi_araddr <= {18'h0, i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask
	task automatic op(input pcstk_op_type o = PCSTK_OP_NONE, input logic [10:0] k = '0,
		input logic [7:0] d = '0, input logic [14:0] a = '0);
		u_pcstk_cpu_model.issue({o, k, d, a});
	endtask
	// Strobe lands one idle edge after the last command took effect
	task automatic chk(input logic [14:0] e);
		q_pc.push_back(e);
		@(posedge aclk);
		pstb <= 1'h1;
		@(posedge aclk);
		pstb <= 1'h0;
	endtask

	// Results are matched in arrival order; a hang ends the run
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_bus(q_bus.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			cmp_bus(q_bus.pop_front(), {s_axi_bresp, 32'h0});
		if (pstb)
			cmp_pc(q_pc.pop_front(), pc);
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		chk(PC_RESET);
		rd(IDX_STACK_INDEX, 8'h1F);
		rd(IDX_UNUSED_GAP, 8'h00, RESP_SLVERR);
		rd(IDX_DEBUG_BANK, 8'h00, RESP_SLVERR);
		wr(IDX_UNUSED_GAP, 8'h00, RESP_SLVERR);
		rd(12'h010, 8'h00);
		wr(IDX_CONTROL, 8'h02);
		wr(IDX_PC_HIGH_LATCH, 8'h55);
		wr(IDX_PC_LOW_BYTE, 8'h34);
		chk(15'h5534);
		rd(IDX_PC_LOW_BYTE, 8'h34);
		wr(IDX_PC_UPPER_BITS, 8'h7F);
		rd(IDX_PC_UPPER_BITS, 8'h00);
		$display("test pc_load done");
		op(PCSTK_OP_CALL, 11'h123);
		op();
		chk(15'h5123);
		rd(IDX_STACK_INDEX, 8'h00);
		rd(IDX_TOP_ENTRY_LOW, 8'h35);
		rd(IDX_TOP_ENTRY_HIGH, 8'h55);
		v = 8'(rnd());
		op(PCSTK_OP_CALL_WORKING, '0, v);
		op();
		chk({7'h55, v});
		op(PCSTK_OP_CALL, 11'h7FF);
		op(PCSTK_OP_RETURN);
		op(PCSTK_OP_RETURN);
		op(PCSTK_OP_RETURN);
		op();
		chk(15'h5535);
		rd(IDX_STACK_INDEX, 8'h1F);
		rd(IDX_PC_HIGH_LATCH, 8'h55);
		$display("test call_return done");
		epc = 15'h5536 + {7'h0, v};
		op(PCSTK_OP_BRANCH_WORKING, '0, v);
		op();
		chk(epc);
		op(PCSTK_OP_BRANCH_LITERAL, 11'h100);
		op();
		chk(epc - 15'h00FF);
		op(PCSTK_OP_WRITE_LOW, '0, 8'h9C);
		op();
		chk(15'h559C);
		wr(IDX_PC_HIGH_LATCH, 8'h7F);
		wr(IDX_PC_LOW_BYTE, 8'hFE);
		op(PCSTK_OP_STEP);
		op(PCSTK_OP_STEP);
		op();
		chk(15'h0000);
		$display("test branch_step done");
		for (int i = 1; i < 18; i++)
			op(PCSTK_OP_VECTOR, .a(15'h100 + 15'(i)));
		op();
		chk(15'h0111);
		rd(IDX_STACK_INDEX, 8'h00);
		rd(IDX_TOP_ENTRY_LOW, 8'h10);
		rd(IDX_POWER_CONTROL_STATUS, 8'h01);
		wr(IDX_POWER_CONTROL_STATUS, 8'h00);
		wr(IDX_STACK_INDEX, 8'h03);
		wr(IDX_TOP_ENTRY_LOW, 8'hAB);
		wr(IDX_TOP_ENTRY_HIGH, 8'h12);
		op(PCSTK_OP_RETURN);
		op();
		chk(15'h12AB);
		rd(IDX_STACK_INDEX, 8'h02);
		wr(IDX_STACK_INDEX, 8'h1F);
		op(PCSTK_OP_RETURN);
		op();
		rd(IDX_POWER_CONTROL_STATUS, 8'h02);
		$display("test wrap_fault_flags done");
		wr(IDX_CONTROL, 8'h03);
		wr(IDX_STACK_INDEX, 8'h0F);
		op(PCSTK_OP_VECTOR, .a(15'h0200));
		op();
		chk(PC_RESET);
		rd(IDX_STACK_INDEX, 8'h1F);
		rd(IDX_POWER_CONTROL_STATUS, 8'h03);
		$display("test fault_reset done");
		ctx = {rnd(), rnd()};
		live_context <= ctx;
		save_context <= 1'h1;
		@(posedge aclk);
		save_context <= 1'h0;
		for (int i = 0; i < 8; i++)
			rd(IDX_STATUS_SHADOW + 12'(i), ctx[63 - 8 * i -: 8]);
		wr(IDX_BANK_SELECT_SHADOW, 8'h5A);
		rd(IDX_BANK_SELECT_SHADOW, 8'h5A);
		s_axi_wstrb <= 4'h0;
		wr(IDX_BANK_SELECT_SHADOW, 8'hA5);
		s_axi_wstrb <= 4'hF;
		rd(IDX_BANK_SELECT_SHADOW, 8'h5A);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		chk(PC_RESET);
		rd(IDX_STACK_INDEX, 8'h1F);
		$display("test shadow_reset done");
		end_sim();
	end
endmodule
`default_nettype wire
